// ===== rtl/mct_timer_family.sv
// Top of the timer family: six counters, timer links, encoder and twelve channels
`timescale 1ns/1ps
module mct_timer_family (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Debug halt
  input wire logic dbgHalt,
  input wire logic dbgOutOff,
  // Per-timer control
  input wire logic [mct_pkg::NUM_TMR-1:0] tmrEn,
  input wire logic [mct_pkg::NUM_TMR-1:0] freezeEn,
  input wire logic [mct_pkg::NUM_TMR-1:0] dmaEn,
  input wire logic [mct_pkg::NUM_TMR-1:0] onePulse,
  input wire logic [mct_pkg::NUM_TMR-1:0] updClr,
  input wire logic [mct_pkg::PSC_W-1:0] psc [mct_pkg::NUM_TMR],
  input wire logic [mct_pkg::CNT_W-1:0] reload [mct_pkg::NUM_TMR],
  input wire logic [mct_pkg::WIDE_W-1:0] reloadWide,
  input wire mct_pkg::mct_cmode_t cntMode [mct_pkg::NUM_TMR],
  input wire mct_pkg::mct_slave_t slaveMode [mct_pkg::NUM_TMR],
  input wire logic [mct_pkg::SEL_W-1:0] trgSel [mct_pkg::NUM_TMR],
  input wire logic [mct_pkg::DT_W-1:0] deadTime [mct_pkg::NUM_TMR],
  // Encoder pins of the wide timer
  input wire logic encEn,
  input wire logic encA,
  input wire logic encB,
  // Per-channel control and pins
  input wire mct_pkg::mct_chmode_t chMode [mct_pkg::NUM_CH],
  input wire logic [mct_pkg::WIDE_W-1:0] cmpVal [mct_pkg::NUM_CH],
  input wire logic [mct_pkg::NUM_CH-1:0] capPol,
  input wire logic [mct_pkg::NUM_CH-1:0] capIn,
  input wire logic [mct_pkg::NUM_CH-1:0] capClr,
  // Kernel clock request
  input wire logic kernelPllReq,
  input wire logic pllIsSys,
  input wire logic [mct_pkg::DIV_W-1:0] busDiv,
  // Counter status
  output wire logic [mct_pkg::WIDE_W-1:0] cntVal [mct_pkg::NUM_TMR],
  output wire logic [mct_pkg::NUM_TMR-1:0] dirDown,
  output wire logic [mct_pkg::NUM_TMR-1:0] updPulse,
  output wire logic [mct_pkg::NUM_TMR-1:0] updFlag,
  output wire logic [mct_pkg::NUM_TMR-1:0] dmaReq,
  output logic dacTrig,
  output logic pllKernelOk,
  // Channel outputs and capture results
  output wire logic [mct_pkg::NUM_CH-1:0] chOut,
  output wire logic [mct_pkg::NUM_CH-1:0] chOutN,
  output wire logic [mct_pkg::WIDE_W-1:0] capVal [mct_pkg::NUM_CH],
  output wire logic [mct_pkg::NUM_CH-1:0] capFlag
);

  // Timer order on every per-timer port: advanced, wide, dual, single a, single b, basic

  // ****************************************
  // Quadrature decoder
  // ****************************************
  // Previous pin samples
  logic encAD;
  logic encBD;

  // Decoded step and direction, and the padded event vector
  logic encStep;
  logic encDir;
  logic [7:0] updVec;

  // Pins are synchronous already; keep the last sample for edge decode
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      encAD <= 1'b0;
      encBD <= 1'b0;
    end else begin
      encAD <= encA;
      encBD <= encB;
    end
  end

  // Four steps per cycle; a jump of both lines at once is an error and is dropped
  assign encStep = encEn & ((encA ^ encAD) ^ (encB ^ encBD));
  assign encDir = encAD ^ encB;

  // Update events of all timers, padded so any select value is a safe index
  assign updVec = {2'b00, updPulse};

  // ****************************************
  // Counters
  // ****************************************
  for (genvar t = 0; t < mct_pkg::NUM_TMR; t++) begin : g_tmr
    localparam int W = (t == mct_pkg::T_WIDE) ? mct_pkg::WIDE_W : mct_pkg::CNT_W;
    localparam bit CAN_DOWN = (t <= mct_pkg::T_WIDE);
    // Center mode needs reload above zero, or the down leg underflows
    // Narrow counters read back zero-extended on the shared status bus

    // Count state
    logic [W-1:0] cnt;
    logic [W-1:0] arr;
    logic [W-1:0] next_cnt;
    logic dir;
    logic next_dir;
    logic wrap;

    // Tick sources
    logic run;
    logic psTick;
    logic tick;

    // Link and external count inputs
    logic trgIn;
    logic trgRst;
    logic useExt;
    logic extStep;
    logic extDir;
    logic stepDown;

    // Stop latch and update outputs
    logic opmDone;
    logic upd;
    logic flag;
    logic dma;

    // Effective count mode
    mct_pkg::mct_cmode_t mode;

    // Reload source by counter width
    if (t == mct_pkg::T_WIDE) begin : g_wide
      assign arr = reloadWide;
      assign useExt = encEn | (slaveMode[t] == mct_pkg::SL_EXTCLK);
      assign extStep = encEn ? encStep : trgIn;
      assign extDir = encEn & encDir;
    end else begin : g_narrow
      assign arr = reload[t];
      assign useExt = (slaveMode[t] == mct_pkg::SL_EXTCLK);
      assign extStep = trgIn;
      assign extDir = 1'b0;
    end

    // Only the advanced and wide timers may leave upcounting
    assign mode = CAN_DOWN ? cntMode[t] : mct_pkg::CM_UP;

    // Timer link: pick another timer's update event
    assign trgIn = updVec[trgSel[t]];
    assign trgRst = (slaveMode[t] == mct_pkg::SL_RESET) & trgIn;

    // Freeze in debug halt when enabled; one-pulse stops after the first update
    assign run = tmrEn[t] & ~(dbgHalt & freezeEn[t]) & ~opmDone;
    assign tick = run & (useExt ? extStep : psTick);
    assign stepDown = useExt ? extDir : (mode == mct_pkg::CM_DOWN);

    // Prescale count freezes with run, so a halted timer resumes mid-period
    mct_prescaler #(
      .W(mct_pkg::PSC_W)
    ) u_psc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .run(run),
      .factor(psc[t]),
      .tick(psTick)
    );

    // Next count; center mode turns at both ends and updates at each turn
    always_comb begin
      next_cnt = cnt;
      next_dir = stepDown;
      wrap = 1'b0;
      if (mode == mct_pkg::CM_CENTER && !useExt) begin
        next_dir = dir;
        if (!dir) begin
          if (cnt >= arr) begin
            next_dir = 1'b1;
            next_cnt = cnt - 1'b1;
            wrap = 1'b1;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end else if (cnt == '0) begin
          next_dir = 1'b0;
          next_cnt = cnt + 1'b1;
          wrap = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end else if (stepDown) begin
        if (cnt == '0) begin
          next_cnt = arr;
          wrap = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end else if (cnt >= arr) begin
        next_cnt = '0;
        wrap = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end

    // Counter and direction; a link reset beats a tick
    // so a running master can re-zero a frozen or stopped slave
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        cnt <= mct_pkg::CNT_RST[W-1:0];
        dir <= 1'b0;
      end else if (trgRst) begin
        cnt <= mct_pkg::CNT_RST[W-1:0];
        dir <= 1'b0;
      end else if (tick) begin
        cnt <= next_cnt;
        dir <= next_dir;
      end
    end

    // Update event, sticky flag and DMA request; a new update beats a clear
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        upd <= 1'b0;
        flag <= 1'b0;
        dma <= 1'b0;
      end else begin
        upd <= tick & wrap;
        dma <= tick & wrap & dmaEn[t];
        if (tick && wrap) begin
          flag <= 1'b1;
        end else if (updClr[t]) begin
          flag <= 1'b0;
        end
      end
    end

    // One-pulse latch, released only by disabling the timer
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        opmDone <= 1'b0;
      end else if (!tmrEn[t]) begin
        opmDone <= 1'b0;
      end else if (tick && wrap && onePulse[t]) begin
        opmDone <= 1'b1;
      end
    end

    // Status outputs come straight from the registers above
    assign cntVal[t] = mct_pkg::WIDE_W'(cnt);
    assign dirDown[t] = dir;
    assign updPulse[t] = upd;
    assign updFlag[t] = flag;
    assign dmaReq[t] = dma;
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar c = 0; c < mct_pkg::NUM_CH; c++) begin : g_ch
    // Channel c runs on timer CH_TMR[c]; wide channels have no low leg
    // Dead time is per timer, so all pairs of one timer share it
    localparam int T = mct_pkg::CH_TMR[c];
    logic forceOff;

    // Only the advanced timer drives power switches, so only it is forced off
    assign forceOff = (T == mct_pkg::T_ADV) & dbgHalt & dbgOutOff;

    // Wide and narrow timers share one channel width; narrow counts are zero-extended
    mct_chan #(
      .W(mct_pkg::WIDE_W),
      .HAS_N(mct_pkg::CH_HAS_N[c])
    ) u_ch (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .mode(chMode[c]),
      .capPol(capPol[c]),
      .cmp(cmpVal[c]),
      .deadTime(deadTime[T]),
      .forceOff(forceOff),
      .cnt(cntVal[T]),
      .capIn(capIn[c]),
      .capClr(capClr[c]),
      .oc(chOut[c]),
      .ocN(chOutN[c]),
      .capVal(capVal[c]),
      .capFlag(capFlag[c])
    );
  end

  // ****************************************
  // DAC trigger and kernel clock
  // ****************************************

  // The basic time base has no channels; its update is the conversion trigger
  // Registered again so the trigger pin comes straight from a flop
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dacTrig <= 1'b0;
    end else begin
      dacTrig <= updPulse[mct_pkg::T_BASE];
    end
  end

  // Fast kernel clock is granted only under the safe clock tree setup
  // Status only: every counter still runs on clk_sys, nothing is switched
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pllKernelOk <= 1'b0;
    end else begin
      pllKernelOk <= kernelPllReq & pllIsSys & (busDiv <= mct_pkg::BUS_DIV_MAX);
    end
  end

endmodule

// ===== rtl/mct_pkg.sv
// Constants and types shared by the multi-channel timer family
//
// Contract
// - The wide general timer has a 32-bit auto-reload counter that counts up, down or up/down.
// - The advanced PWM timer has four channels for capture, compare, PWM or one-pulse output.
// - The advanced PWM timer drives three complementary pairs with programmable dead time.
// - The advanced PWM timer makes edge- or center-aligned PWM with duty from 0 to 100 percent.
// - In debug halt the advanced counter can stop and its PWM outputs are forced inactive.
// - The advanced and general timers are linked so one timer's events sync or chain another.
// - The wide general timer decodes quadrature encoder inputs and raises its own DMA requests.
// - The wide general timer has four capture/compare channels and can stop in debug halt.
// - The mid-range timers use 16-bit auto-reload upcounters and never count down.
// - The dual channel timer has two channels and only its first has a complementary output.
// - Each single channel timer has one channel with a complementary output.
// - Every mid-range channel selects capture, compare, PWM or one-pulse output.
// - Each mid-range timer raises its own DMA requests and can stop in debug halt.
// - The basic time base is a 16-bit upcounter with no channels that triggers the DAC.
// - The 144 MHz PLL kernel clock is allowed only with PLL system clock and bus division <= 2.
package mct_pkg;

  // ****************************************
  // Sizes and indices
  // ****************************************
  localparam int NUM_TMR = 6;
  localparam int NUM_CH = 12;
  localparam int T_ADV = 0;
  localparam int T_WIDE = 1;
  localparam int T_DUAL = 2;
  localparam int T_SNGA = 3;
  localparam int T_SNGB = 4;
  localparam int T_BASE = 5;
  localparam int PSC_W = 16;
  localparam int CNT_W = 16;
  localparam int WIDE_W = 32;
  localparam int DT_W = 8;
  localparam int SEL_W = 3;
  localparam int DIV_W = 4;

  // Channel to timer map; advanced 0-3, wide 4-7, dual 8-9, single a 10, single b 11
  localparam int CH_TMR [NUM_CH] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 4};
  // Channels with a complementary output
  localparam logic [NUM_CH-1:0] CH_HAS_N = 12'hd07;

  // ****************************************
  // Clocking and reset values
  // ****************************************
  localparam int PLL_KER_MHZ = 144;
  localparam logic [DIV_W-1:0] BUS_DIV_MAX = 4'h2;
  localparam logic [WIDE_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
  localparam logic [DT_W-1:0] DT_RST = 8'h00;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    CM_UP = 2'b00,
    CM_DOWN = 2'b01,
    CM_CENTER = 2'b10
  } mct_cmode_t;

  typedef enum logic [1:0] {
    CH_CAPTURE = 2'b00,
    CH_COMPARE = 2'b01,
    CH_PWM = 2'b10,
    CH_ONEPULSE = 2'b11
  } mct_chmode_t;

  typedef enum logic [1:0] {
    SL_NONE = 2'b00,
    SL_RESET = 2'b01,
    SL_EXTCLK = 2'b10
  } mct_slave_t;

endpackage

// ===== rtl/mct_prescaler.sv
// Clock prescaler that turns the system clock into counter ticks
`timescale 1ns/1ps
module mct_prescaler #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [W-1:0] factor,
  // Tick out
  output wire logic tick
);

  logic [W-1:0] pc;

  // Division by factor plus one; compare with >= so a smaller factor never runs past
  assign tick = run & (pc >= factor);

  // Prescale count holds while the timer is stopped or frozen
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pc <= W'(mct_pkg::PSC_RST);
    end else if (run) begin
      pc <= tick ? '0 : pc + 1'b1;
    end
  end

endmodule

// ===== rtl/mct_chan.sv
// Capture/compare channel with optional dead-time complementary output
`timescale 1ns/1ps
module mct_chan #(
  parameter int W = 32,
  parameter bit HAS_N = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration
  input wire mct_pkg::mct_chmode_t mode,
  input wire logic capPol,
  input wire logic [W-1:0] cmp,
  input wire logic [mct_pkg::DT_W-1:0] deadTime,
  input wire logic forceOff,
  // Counter and pins
  input wire logic [W-1:0] cnt,
  input wire logic capIn,
  input wire logic capClr,
  output logic oc,
  output logic ocN,
  output logic [W-1:0] capVal,
  output logic capFlag
);

  logic capInD;
  logic capEdge;
  logic match;
  logic matchD;
  logic tog;
  logic refWave;
  logic refWaveD;
  logic settle;
  logic [mct_pkg::DT_W-1:0] dtCnt;

  // Edge of the selected polarity on the capture pin
  assign capEdge = (capIn ^ capInD) & (capIn ^ capPol);
  assign match = (cnt == cmp);

  // Reference waveform per mode; in PWM cmp 0 gives 0 % and cmp above reload gives 100 %
  always_comb begin
    unique case (mode)
      mct_pkg::CH_CAPTURE: refWave = 1'b0;
      mct_pkg::CH_COMPARE: refWave = tog;
      mct_pkg::CH_PWM: refWave = (cnt < cmp);
      mct_pkg::CH_ONEPULSE: refWave = (cnt >= cmp);
    endcase
  end

  // Capture latch; a new capture beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      capInD <= 1'b0;
      capVal <= '0;
      capFlag <= 1'b0;
    end else begin
      capInD <= capIn;
      if (mode == mct_pkg::CH_CAPTURE && capEdge) begin
        capVal <= cnt;
        capFlag <= 1'b1;
      end else if (capClr) begin
        capFlag <= 1'b0;
      end
    end
  end

  // Toggle on the first cycle of a match, not on every cycle it lasts
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      matchD <= 1'b0;
      tog <= 1'b0;
    end else begin
      matchD <= match;
      if (mode != mct_pkg::CH_COMPARE) begin
        tog <= 1'b0;
      end else if (match && !matchD) begin
        tog <= ~tog;
      end
    end
  end

  // Dead-time counter restarts on each reference edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      refWaveD <= 1'b0;
      dtCnt <= mct_pkg::DT_RST;
    end else begin
      refWaveD <= refWave;
      if (refWave != refWaveD) begin
        dtCnt <= deadTime;
      end else if (dtCnt != '0) begin
        dtCnt <= dtCnt - 1'b1;
      end
    end
  end

  // Both legs low until the dead time has run out, so the pair never overlaps
  assign settle = (refWave == refWaveD) && (dtCnt == '0);

  // Registered pin drive; forceOff turns both legs off
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      oc <= 1'b0;
      ocN <= 1'b0;
    end else begin
      oc <= ~forceOff & refWave & (settle | ~HAS_N);
      ocN <= HAS_N & ~forceOff & (mode != mct_pkg::CH_CAPTURE) & ~refWave & settle;
    end
  end

endmodule

// ===== verif/mct_timer_family_asserts.sv
// Port checker for the timer family top
`timescale 1ns/1ps
module mct_timer_family_asserts (
  // Clock, reset and debug
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic dbgHalt,
  input wire logic dbgOutOff,
  // Control
  input wire logic [mct_pkg::NUM_TMR-1:0] freezeEn,
  input wire logic [mct_pkg::NUM_TMR-1:0] updClr,
  input wire logic kernelPllReq,
  input wire logic pllIsSys,
  input wire logic [mct_pkg::DIV_W-1:0] busDiv,
  // Results
  input wire logic [mct_pkg::WIDE_W-1:0] cntVal [mct_pkg::NUM_TMR],
  input wire logic [mct_pkg::NUM_TMR-1:0] updPulse,
  input wire logic [mct_pkg::NUM_TMR-1:0] updFlag,
  input wire logic [mct_pkg::NUM_TMR-1:0] dmaReq,
  input logic dacTrig,
  input logic pllKernelOk,
  input wire logic [mct_pkg::NUM_CH-1:0] chOut,
  input wire logic [mct_pkg::NUM_CH-1:0] chOutN
);
  // ********
  // Properties
  // ********
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_dma;
    dmaReq != 6'h00 |-> (dmaReq & ~updPulse) == 6'h00;
  endproperty
  // Grant is one cycle late; skip the edge right after reset
  property p_pll;
    $past(nrst) |-> pllKernelOk == ($past(kernelPllReq && pllIsSys) && ($past(busDiv) <= 4'h2));
  endproperty
  property p_flag;
    updPulse != 6'h00 |-> (updPulse & ~updFlag) == 6'h00;
  endproperty
  property p_clr;
    $past(updClr[5]) && !updPulse[5] |-> !updFlag[5];
  endproperty
  property p_non;
    (chOutN & ~mct_pkg::CH_HAS_N) == 12'h000;
  endproperty
  property p_legs;
    (chOut & chOutN) == 12'h000;
  endproperty
  property p_off;
    $past(dbgHalt && dbgOutOff) |-> (chOut[3:0] | chOutN[3:0]) == 4'h0;
  endproperty
  property p_frz;
    $past(nrst) && $past(dbgHalt && freezeEn[0]) |-> $stable(cntVal[0]);
  endproperty
  property p_mid;
    updPulse[2] |-> cntVal[2] == 32'h0;
  endproperty
  property p_base;
    updPulse[5] |-> cntVal[5] == 32'h0 ##1 dacTrig;
  endproperty
  a_dma: assert property (p_dma) else $error("dma request without update");
  a_pll: assert property (p_pll) else $error("kernel grant wrong");
  a_flag: assert property (p_flag) else $error("update flag not set");
  a_clr: assert property (p_clr) else $error("update flag not cleared");
  a_non: assert property (p_non) else $error("complementary leg on plain channel");
  a_legs: assert property (p_legs) else $error("both legs high");
  a_off: assert property (p_off) else $error("outputs on in halt");
  a_frz: assert property (p_frz) else $error("counter moved in halt");
  a_mid: assert property (p_mid) else $error("mid timer not wrapping to zero");
  a_base: assert property (p_base) else $error("converter trigger missing");
  c_upd: cover property (updPulse[0]);
  c_off: cover property (dbgHalt && dbgOutOff);
  c_dma: cover property (dmaReq[1]);
endmodule

// ===== verif/mct_far_side.sv
// Far side model: quadrature encoder and capture signal source
`timescale 1ns/1ps
module mct_far_side (
  // Clock
  input wire logic clk_sys,
  // Commands from the bench
  input wire logic stepReq,
  input wire logic stepUp,
  input wire logic edgeReq,
  // Pins toward the timers
  output wire logic encA,
  output wire logic encB,
  output wire logic capPin
);
  logic [1:0] ph = 2'h0;
  logic pin = 1'b0;
  // ********
  // Pin sources
  // ********
  // Gray walk 00,10,11,01 so only one line moves per step
  always @(posedge clk_sys) begin
    if (stepReq) ph <= stepUp ? ph + 2'h1 : ph - 2'h1;
  end
  assign encA = (ph == 2'h1) || (ph == 2'h2);
  assign encB = ph[1];
  // Level source flips once per command
  always @(posedge clk_sys) begin
    if (edgeReq) pin <= ~pin;
  end
  assign capPin = pin;
endmodule

// ===== verif/mct_timer_family_tb_top.sv
// Top testbench of the timer family
`timescale 1ns/1ps
module mct_timer_family_tb_top;
  // ********
  // Stimulus and results
  // ********
  logic clk_sys = 1'b0, nrst = 1'b0, dbgHalt = 1'b0, dbgOutOff = 1'b0, encEn = 1'b0;
  logic [5:0] tmrEn = 6'h00, freezeEn = 6'h00, dmaEn = 6'h00, onePulse = 6'h00, updClr = 6'h00;
  logic [15:0] psc [6], reload [6];
  logic [31:0] reloadWide = 32'h0, cmpVal [12];
  mct_pkg::mct_cmode_t cntMode [6];
  mct_pkg::mct_slave_t slaveMode [6];
  mct_pkg::mct_chmode_t chMode [12];
  logic [2:0] trgSel [6];
  logic [7:0] deadTime [6];
  logic [11:0] capPol = 12'h000, capClr = 12'h000;
  logic kernelPllReq = 1'b0, pllIsSys = 1'b0, stepReq = 1'b0, stepUp = 1'b0, edgeReq = 1'b0;
  logic [3:0] busDiv = 4'h0;
  wire logic encA, encB, capPin;
  logic dacTrig, pllKernelOk;
  wire logic [11:0] capIn = {1'b0, capPin, 10'h000};
  wire logic [31:0] cntVal [6], capVal [12];
  wire logic [5:0] dirDown, updPulse, updFlag, dmaReq;
  wire logic [11:0] chOut, chOutN, capFlag;
  int n_fail = 0, n_checks = 0;

  mct_timer_family u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .dbgHalt(dbgHalt), .dbgOutOff(dbgOutOff),
    .tmrEn(tmrEn), .freezeEn(freezeEn), .dmaEn(dmaEn), .onePulse(onePulse),
    .updClr(updClr), .psc(psc), .reload(reload), .reloadWide(reloadWide),
    .cntMode(cntMode), .slaveMode(slaveMode), .trgSel(trgSel), .deadTime(deadTime),
    .encEn(encEn), .encA(encA), .encB(encB), .chMode(chMode), .cmpVal(cmpVal),
    .capPol(capPol), .capIn(capIn), .capClr(capClr), .kernelPllReq(kernelPllReq),
    .pllIsSys(pllIsSys), .busDiv(busDiv), .cntVal(cntVal), .dirDown(dirDown),
    .updPulse(updPulse), .updFlag(updFlag), .dmaReq(dmaReq), .dacTrig(dacTrig),
    .pllKernelOk(pllKernelOk), .chOut(chOut), .chOutN(chOutN), .capVal(capVal),
    .capFlag(capFlag)
  );
  mct_far_side u_far (
    .clk_sys(clk_sys), .stepReq(stepReq), .stepUp(stepUp), .edgeReq(edgeReq),
    .encA(encA), .encB(encB), .capPin(capPin)
  );

  // ********
  // Helpers
  // ********
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Sample one ns after the edge so its updates have landed
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait for an update; n counts the edges waited
  task automatic wup(input int t, output int n);
    n = 0;
    while (updPulse[t] !== 1'b1) begin
      cyc();
      n++;
      if (n > 400) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  task automatic rst();
    @(posedge clk_sys) nrst <= 1'b0;
    tmrEn <= 6'h00;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  // ********
  // Scenarios
  // ********
  // Basic base: prescaler period, trigger, flag clear, link count, kernel grant
  task automatic t_base();
    int n;
    rst();
    @(posedge clk_sys) begin
      psc[5] <= 16'h0001;
      reload[5] <= 16'h0002;
      dmaEn <= 6'h20;
      slaveMode[4] <= mct_pkg::SL_EXTCLK;
      trgSel[4] <= 3'h5;
      reload[4] <= 16'h0064;
      kernelPllReq <= 1'b1;
      pllIsSys <= 1'b1;
      busDiv <= 4'h2;
      tmrEn <= 6'h30;
    end
    wup(5, n);
    chk("cnt5", 32'h0, cntVal[5]);
    chk("dma5", 1, dmaReq[5]);
    chk("flag5", 1, updFlag[5]);
    chk("pll", 1, pllKernelOk);
    cyc();
    chk("dac", 1, dacTrig);
    wup(5, n);
    chk("period5", 5, n);
    cyc();
    cyc();
    chk("link4", 2, cntVal[4]);
    @(posedge clk_sys) updClr <= 6'h20;
    busDiv <= 4'h3;
    @(posedge clk_sys) updClr <= 6'h00;
    cyc();
    chk("clr5", 0, updFlag[5]);
    chk("pll", 0, pllKernelOk);
    $display("test base done");
  endtask
  // Down count on the wide timer, down request ignored on a mid timer
  task automatic t_dir();
    int n;
    rst();
    @(posedge clk_sys) begin
      cntMode[1] <= mct_pkg::CM_DOWN;
      cntMode[2] <= mct_pkg::CM_DOWN;
      reloadWide <= 32'h0001_0002;
      reload[2] <= 16'h0003;
      slaveMode[2] <= mct_pkg::SL_RESET;
      trgSel[2] <= 3'h1;
      dmaEn <= 6'h02;
      tmrEn <= 6'h06;
    end
    wup(1, n);
    chk("wide", 32'h0001_0002, cntVal[1]);
    chk("dir1", 1, dirDown[1]);
    chk("dma1", 1, dmaReq[1]);
    cyc();
    wup(2, n);
    chk("link2", 4, n);
    chk("cnt2", 32'h0, cntVal[2]);
    chk("dir2", 0, dirDown[2]);
    chk("wide", 32'h0000_fffd, cntVal[1]);
    $display("test dir done");
  endtask
  // Center PWM with dead time, full-scale duty, debug halt
  task automatic t_pwm();
    int n;
    rst();
    @(posedge clk_sys) begin
      cntMode[0] <= mct_pkg::CM_CENTER;
      reload[0] <= 16'h0009;
      reload[2] <= 16'h0009;
      deadTime[0] <= 8'h02;
      cmpVal[0] <= 32'h64;
      freezeEn <= 6'h01;
      onePulse <= 6'h04;
      tmrEn <= 6'h05;
    end
    wup(0, n);
    cyc();
    wup(0, n);
    chk("center", 8, n);
    chk("pwm0", 1, chOut[0]);
    chk("pwm0n", 0, chOutN[0]);
    chk("pwm8", 0, chOut[8]);
    chk("pwm8n", 1, chOutN[8]);
    chk("cap3", 0, chOut[3]);
    chk("opm2", 0, cntVal[2]);
    chk("os2", 1, chOut[2]);
    @(posedge clk_sys) dbgHalt <= 1'b1;
    dbgOutOff <= 1'b1;
    repeat (3) cyc();
    chk("off0", 0, chOut[0]);
    chk("off0n", 0, chOutN[0]);
    n = cntVal[0];
    cyc();
    chk("frz0", n, cntVal[0]);
    @(posedge clk_sys) dbgHalt <= 1'b0;
    dbgOutOff <= 1'b0;
    repeat (8) cyc();
    chk("back0", 1, chOut[0]);
    @(posedge clk_sys) cmpVal[0] <= 32'h0;
    repeat (3) cyc();
    chk("dead0", 0, chOut[0] | chOutN[0]);
    cyc();
    chk("dead0n", 1, chOutN[0]);
    $display("test pwm done");
  endtask
  // Encoder: five steps up, two down
  task automatic t_enc();
    rst();
    @(posedge clk_sys) begin
      encEn <= 1'b1;
      reloadWide <= 32'h0000_ffff;
      tmrEn <= 6'h02;
    end
    @(posedge clk_sys) stepUp <= 1'b1;
    stepReq <= 1'b1;
    repeat (5) @(posedge clk_sys);
    stepUp <= 1'b0;
    repeat (2) @(posedge clk_sys);
    stepReq <= 1'b0;
    repeat (3) cyc();
    chk("enc", 3, cntVal[1]);
    encEn <= 1'b0;
    $display("test enc done");
  endtask
  // Capture on single channel a, then clear
  task automatic t_cap();
    int n;
    rst();
    @(posedge clk_sys) begin
      reload[3] <= 16'h0005;
      tmrEn <= 6'h08;
    end
    wup(3, n);
    @(posedge clk_sys) edgeReq <= 1'b1;
    @(posedge clk_sys) edgeReq <= 1'b0;
    cyc();
    chk("capv", 2, capVal[10]);
    chk("capf", 1, capFlag[10]);
    @(posedge clk_sys) capClr <= 12'h400;
    @(posedge clk_sys) capClr <= 12'h000;
    #1;
    chk("capclr", 0, capFlag[10]);
    $display("test cap done");
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      psc[i] = 16'h0;
      reload[i] = 16'h0;
      cntMode[i] = mct_pkg::CM_UP;
      slaveMode[i] = mct_pkg::SL_NONE;
      trgSel[i] = 3'h7;
      deadTime[i] = 8'h0;
    end
    for (int i = 0; i < 12; i++) begin
      cmpVal[i] = 32'h0;
      chMode[i] = mct_pkg::CH_PWM;
    end
    chMode[1] = mct_pkg::CH_COMPARE;
    chMode[2] = mct_pkg::CH_ONEPULSE;
    chMode[3] = mct_pkg::CH_CAPTURE;
    chMode[10] = mct_pkg::CH_CAPTURE;
    t_base();
    t_dir();
    t_pwm();
    t_enc();
    t_cap();
    tally_and_finish();
  end
endmodule

bind mct_timer_family mct_timer_family_asserts u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .dbgHalt(dbgHalt), .dbgOutOff(dbgOutOff),
  .freezeEn(freezeEn), .updClr(updClr), .kernelPllReq(kernelPllReq),
  .pllIsSys(pllIsSys), .busDiv(busDiv), .cntVal(cntVal), .updPulse(updPulse),
  .updFlag(updFlag), .dmaReq(dmaReq), .dacTrig(dacTrig), .pllKernelOk(pllKernelOk),
  .chOut(chOut), .chOutN(chOutN)
);
